// File: src/fcec_checker.sv
// Flash command launch checker with Avalon-MM register slave
//
// Summary of operation
// R01: Sector erase, field margin need index 001.
// R02: Unsecure launch needs index 000.
// R03: Command not allowed in mode: access error.
// R04: Sector erase bad block bits: access error.
// R05: Sector erase misaligned phrase: access error.
// R06: Sector erase protected sector: protection violation.
// R07: Erase or unsecure: any verify error sets verify error flag.
// R08: Erase or unsecure: uncorrectable verify error sets uncorrectable flag.
// R09: Unsecure code 0b erases all memory.
// R10: Unsecure verify passes: release secure state.
// R11: Unsecure verify fails: error, security kept.
// R12: Unsecure with any protection: protection violation.
// R13: Software writes nothing while command runs.
// R14: Clearing complete flag starts; finish sets it.
// R15: Field margin bad block code: access error.
// R16: Field margin bad level: access error.
// R17: EEPROM verify words at indices 000-010.
// R18: EEPROM section verify, then complete flag.
// R19: EEPROM blank check fail sets both flags.
// R20: Secure input and mode gate commands.
// R21: Launch error: no execution, complete stays set.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module fcec_checker #(
  parameter int EXEC_LEN = fcec_pkg::EXEC_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // MCU mode and security pins
  input  wire logic        special_mode_in,
  input  wire logic        secure_in,
  // Array verify results
  input  wire logic        verify_fail_in,
  input  wire logic        verify_uncorr_in,
  // Array operation outputs
  output logic             erase_all_out,
  output logic             verify_busy_out,
  output logic             secure_state
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {special_mode_in, secure_in, verify_fail_in, verify_uncorr_in};
      sync2_reg <= sync1_reg;
    end
  end
  logic special_s, secure_s, vfail_s, vunc_s;
  assign {special_s, secure_s, vfail_s, vunc_s} = sync2_reg;

  // ----------------------------------------------------------------
  // Mode permission decode
  // ----------------------------------------------------------------
  function automatic logic cmd_allowed(input logic [7:0] cmd, input logic ss,
                                       input logic sec);
    case (cmd)
      fcec_pkg::CMD_ERASE_SECTOR: cmd_allowed = !(sec && ss);
      fcec_pkg::CMD_UNSECURE:     cmd_allowed = ss;
      fcec_pkg::CMD_FIELD_MARGIN: cmd_allowed = ss && !sec;
      fcec_pkg::CMD_EV_EEPROM:    cmd_allowed = !(sec && ss);
      default:                    cmd_allowed = 1'b0;
    endcase
  endfunction : cmd_allowed

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fcec_pkg::fcec_state_type state_reg, state_next;
  fcec_pkg::fcec_flags_type flags_reg, flags_next;
  logic [2:0]  index_reg, index_next;
  logic [15:0] words_reg [0:5];
  logic [15:0] words_next [0:5];
  logic [3:0]  prot_reg, prot_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic        sec_rel_reg, sec_rel_next;
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;

  // ----------------------------------------------------------------
  // Bus acceptance
  // ----------------------------------------------------------------
  logic rd_start;
  logic wr_take;
  assign rd_start = avs_read && !wait_reg;
  assign wr_take  = avs_write && wait_reg;

  // ----------------------------------------------------------------
  // Effective security state
  // ----------------------------------------------------------------
  logic sec_eff;
  assign sec_eff = secure_s && !sec_rel_reg; // R10 R20

  logic [7:0] cur_cmd;
  logic       launch;
  logic       acc_err;
  logic       prot_err;
  assign cur_cmd = words_reg[0][15:8];
  assign launch  = wr_take && (avs_address == fcec_pkg::OFS_STATUS)
                   && avs_byteenable[0] && avs_writedata[fcec_pkg::STAT_COMPLETE]
                   && flags_reg.complete;

  // ----------------------------------------------------------------
  // Launch checks
  // ----------------------------------------------------------------
  always_comb begin
    acc_err  = 1'b0;
    prot_err = 1'b0;
    if (!cmd_allowed(cur_cmd, special_s, sec_eff)) acc_err = 1'b1; // R03 R20
    case (cur_cmd)
      fcec_pkg::CMD_ERASE_SECTOR: begin
        if (index_reg != fcec_pkg::IDX_ONE) acc_err = 1'b1; // R01
        if (words_reg[0][1:0] != fcec_pkg::PFLASH_BLOCK) acc_err = 1'b1; // R04
        if (words_reg[1][2:0] != 3'h0) acc_err = 1'b1; // R05
        if (prot_reg[words_reg[1][15:14]]) prot_err = 1'b1; // R06
      end
      fcec_pkg::CMD_UNSECURE: begin
        if (index_reg != fcec_pkg::IDX_ZERO) acc_err = 1'b1; // R02
        if (prot_reg != 4'h0) prot_err = 1'b1; // R12
      end
      fcec_pkg::CMD_FIELD_MARGIN: begin
        if (index_reg != fcec_pkg::IDX_ONE) acc_err = 1'b1; // R01
        if (words_reg[0][1:0] != fcec_pkg::PFLASH_BLOCK
            && words_reg[0][1:0] != fcec_pkg::EEPROM_BLOCK) acc_err = 1'b1; // R15
        if (words_reg[1] != fcec_pkg::MARGIN_NORMAL
            && words_reg[1] != fcec_pkg::MARGIN_HIGH) acc_err = 1'b1; // R16
      end
      fcec_pkg::CMD_EV_EEPROM: begin
        if (index_reg != fcec_pkg::IDX_TWO) acc_err = 1'b1;
        if (words_reg[0][1:0] != fcec_pkg::EEPROM_BLOCK) acc_err = 1'b1;
      end
      default: acc_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    flags_next   = flags_reg;
    index_next   = index_reg;
    prot_next    = prot_reg;
    cnt_next     = cnt_reg;
    cmd_next     = cmd_reg;
    sec_rel_next = sec_rel_reg;
    wait_next    = 1'b0;
    rdata_next   = rdata_reg;
    for (int i = 0; i < 6; i++) begin
      words_next[i] = words_reg[i];
    end
    // Bus access takes one wait cycle
    if ((avs_read || avs_write) && !wait_reg) begin
      wait_next = 1'b1;
    end
    if (rd_start) begin
      case (avs_address)
        fcec_pkg::OFS_STATUS:
          rdata_next = {24'h0, flags_reg.complete, 1'b0, flags_reg.access_error_flag, flags_reg.pviol,
                        2'h0, flags_reg.verr, flags_reg.vunc};
        fcec_pkg::OFS_INDEX:   rdata_next = {29'h0, index_reg};
        fcec_pkg::OFS_CMDWORD: begin
          if (index_reg <= fcec_pkg::IDX_LAST) begin
            rdata_next = {16'h0, words_reg[index_reg]};
          end else begin
            rdata_next = 32'h0;
          end
        end
        fcec_pkg::OFS_PROTECT: rdata_next = {28'h0, prot_reg};
        default:               rdata_next = 32'h0;
      endcase
    end
    // Writes are ignored while a command runs
    if (wr_take && flags_reg.complete) begin // R13
      case (avs_address)
        fcec_pkg::OFS_STATUS: if (avs_byteenable[0]) begin
          if (avs_writedata[fcec_pkg::STAT_ACCESS_ERROR_FLAG]) flags_next.access_error_flag = 1'b0;
          if (avs_writedata[fcec_pkg::STAT_PVIOL])  flags_next.pviol  = 1'b0;
        end
        fcec_pkg::OFS_INDEX: if (avs_byteenable[0]) begin
          index_next = avs_writedata[2:0];
        end
        fcec_pkg::OFS_CMDWORD: if (index_reg <= fcec_pkg::IDX_LAST) begin
          if (avs_byteenable[0]) words_next[index_reg][7:0]  = avs_writedata[7:0];
          if (avs_byteenable[1]) words_next[index_reg][15:8] = avs_writedata[15:8];
        end
        fcec_pkg::OFS_PROTECT: if (avs_byteenable[0]) begin
          prot_next = prot_reg | avs_writedata[3:0];
        end
        default: ;
      endcase
    end
    case (state_reg)
      fcec_pkg::ST_IDLE: begin
        if (launch && !flags_reg.access_error_flag && !flags_reg.pviol) begin
          flags_next.verr = 1'b0;
          flags_next.vunc = 1'b0;
          if (acc_err || prot_err) begin
            flags_next.access_error_flag = acc_err; // R21
            flags_next.pviol  = prot_err; // R21
          end else begin
            flags_next.complete = 1'b0; // R14
            cmd_next   = cur_cmd;
            cnt_next   = 8'(EXEC_LEN - 1);
            state_next = fcec_pkg::ST_EXEC;
          end
        end
      end
      fcec_pkg::ST_EXEC: begin
        if (cnt_reg == 8'h0) begin
          cnt_next   = 8'(EXEC_LEN - 1);
          state_next = fcec_pkg::ST_VERIFY;
        end else begin
          cnt_next = cnt_reg - 8'h1;
        end
      end
      fcec_pkg::ST_VERIFY: begin
        if (cnt_reg == 8'h0) begin
          state_next          = fcec_pkg::ST_IDLE;
          flags_next.complete = 1'b1; // R14 R18
          if (cmd_reg == fcec_pkg::CMD_EV_EEPROM) begin
            if (vfail_s) begin
              flags_next.verr = 1'b1; // R19
              flags_next.vunc = 1'b1; // R19
            end
          end else if (cmd_reg == fcec_pkg::CMD_ERASE_SECTOR
                       || cmd_reg == fcec_pkg::CMD_UNSECURE) begin
            flags_next.verr = vfail_s || vunc_s; // R07 R11
            flags_next.vunc = vunc_s; // R08
            if (cmd_reg == fcec_pkg::CMD_UNSECURE && !vfail_s && !vunc_s) begin
              sec_rel_next = 1'b1; // R10
            end
          end
        end else begin
          cnt_next = cnt_reg - 8'h1;
        end
      end
      default: state_next = fcec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= fcec_pkg::ST_IDLE;
      flags_reg   <= '{complete: 1'b1, default: 1'b0};
      index_reg   <= fcec_pkg::INDEX_RESET;
      prot_reg    <= fcec_pkg::PROT_RESET;
      cnt_reg     <= 8'h0;
      cmd_reg     <= 8'h0;
      sec_rel_reg <= 1'b0;
      wait_reg    <= 1'b0;
      rdata_reg   <= 32'h0;
      for (int i = 0; i < 6; i++) begin
        words_reg[i] <= 16'h0;
      end
    end else begin
      state_reg   <= state_next;
      flags_reg   <= flags_next;
      index_reg   <= index_next;
      prot_reg    <= prot_next;
      cnt_reg     <= cnt_next;
      cmd_reg     <= cmd_next;
      sec_rel_reg <= sec_rel_next;
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      for (int i = 0; i < 6; i++) begin
        words_reg[i] <= words_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !wait_reg;
  assign avs_readdata    = rdata_reg;
  assign erase_all_out   = (state_reg == fcec_pkg::ST_EXEC)
                           && (cmd_reg == fcec_pkg::CMD_UNSECURE); // R09
  assign verify_busy_out = (state_reg == fcec_pkg::ST_VERIFY);
  assign secure_state    = sec_eff; // R10 R11

endmodule : fcec_checker
`default_nettype wire

// File: src/fcec_pkg.sv
// Package for the flash command launch checker
package fcec_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS   = 4'h0;
  localparam logic [3:0] OFS_INDEX    = 4'h4;
  localparam logic [3:0] OFS_CMDWORD  = 4'h8;
  localparam logic [3:0] OFS_PROTECT  = 4'hc;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int STAT_COMPLETE = 7;
  localparam int STAT_ACCESS_ERROR_FLAG   = 5;
  localparam int STAT_PVIOL    = 4;
  localparam int STAT_VERR     = 1;
  localparam int STAT_VUNC     = 0;

  // ----------------------------------------------------------------
  // Command codes and indices
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
  localparam logic [7:0] CMD_UNSECURE     = 8'h0b;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_EV_EEPROM    = 8'h10;
  localparam logic [2:0] IDX_ZERO         = 3'h0;
  localparam logic [2:0] IDX_ONE          = 3'h1;
  localparam logic [2:0] IDX_TWO          = 3'h2;
  localparam logic [2:0] IDX_LAST         = 3'h5;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] PROT_RESET     = 4'h0;
  localparam logic [2:0] INDEX_RESET    = 3'h0;
  localparam int         EXEC_CYCLES    = 16;
  localparam logic [1:0] PFLASH_BLOCK   = 2'h0;
  localparam logic [1:0] EEPROM_BLOCK   = 2'h1;
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_HIGH   = 16'h0002;

  // Status flags carried together
  typedef struct packed {
    logic complete;
    logic access_error_flag;
    logic pviol;
    logic verr;
    logic vunc;
  } fcec_flags_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_VERIFY = 2'b10
  } fcec_state_type;

endpackage : fcec_pkg

// File: tb/fcec_checker_assertions.sv
// Port assertions for the flash command launch checker
`timescale 1ns/1ps
`default_nettype none
module fcec_checker_sva #(
  parameter int EXEC_LEN = fcec_pkg::EXEC_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic        secure_in,
  input wire logic        erase_all_out,
  input wire logic        verify_busy_out,
  input wire logic        secure_state
);
  // ----------------------------------------------------------------
  // Phase length counters
  // ----------------------------------------------------------------
  logic [8:0] er_cnt;
  logic [8:0] vb_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      er_cnt <= 9'h000;
      vb_cnt <= 9'h000;
    end else begin
      er_cnt <= erase_all_out ? er_cnt + 9'h001 : 9'h000;
      vb_cnt <= verify_busy_out ? vb_cnt + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_first_wait;
    !(avs_read || avs_write) ##1 (avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  property p_rd_stand;
    !$stable(avs_readdata) |-> $past(avs_read && avs_waitrequest);
  endproperty
  property p_excl;
    !(erase_all_out && verify_busy_out);
  endproperty
  property p_er_len;
    $fell(erase_all_out) |-> er_cnt == 9'(EXEC_LEN);
  endproperty
  property p_vb_len;
    $fell(verify_busy_out) |-> vb_cnt == 9'(EXEC_LEN);
  endproperty
  property p_er_then_vb;
    $fell(erase_all_out) |-> verify_busy_out;
  endproperty
  property p_er_launch;
    $rose(erase_all_out) |-> $past(avs_write && !avs_waitrequest);
  endproperty
  property p_sec;
    secure_state |-> $past(secure_in, 2);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
  a_first_wait: assert property (p_first_wait) else $error("no wait cycle");
  a_rd_stand: assert property (p_rd_stand) else $error("readdata moved");
  a_excl: assert property (p_excl) else $error("erase and verify overlap");
  a_er_len: assert property (p_er_len) else $error("erase length");
  a_vb_len: assert property (p_vb_len) else $error("verify length");
  a_er_then_vb: assert property (p_er_then_vb) else $error("no verify after erase");
  a_er_launch: assert property (p_er_launch) else $error("erase without launch");
  a_sec: assert property (p_sec) else $error("secure without pin");
  c_erase: cover property ($rose(erase_all_out));
  c_release: cover property ($fell(secure_state));
  c_verify: cover property ($fell(verify_busy_out));
endmodule : fcec_checker_sva
bind fcec_checker fcec_checker_sva #(.EXEC_LEN(EXEC_LEN)) fcec_checker_sva_inst (
  .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .secure_in(secure_in),
  .erase_all_out(erase_all_out), .verify_busy_out(verify_busy_out),
  .secure_state(secure_state));
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the flash command launch checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic sp_in = 1'b0, sc_in = 1'b0, vf_in = 1'b0, vu_in = 1'b0;
  logic avs_waitrequest, erase_all_out, verify_busy_out, secure_state;
  logic [3:0]  avs_address = 4'h0, prot = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [15:0] w;
  logic [1:0]  k;
  int n_errors = 0, num_checks = 0, rel = 0;
  always #10 clk = ~clk;
  fcec_checker #(.EXEC_LEN(4)) fcec_checker_inst (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .special_mode_in(sp_in), .secure_in(sc_in),
    .verify_fail_in(vf_in), .verify_uncorr_in(vu_in), .erase_all_out(erase_all_out),
    .verify_busy_out(verify_busy_out), .secure_state(secure_state));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk);
      ok = (avs_waitrequest === 1'b0);
      rd = avs_readdata;
      @(posedge clk);
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
    if (!ok) begin
      n_errors++;
      end_of_test();
    end
  endtask : bus
  task automatic run(input logic [7:0] c, input logic [2:0] ix, input logic [1:0] b,
    input logic [15:0] w1, input logic sp, input logic sc, input logic vf, input logic vu,
    input string s);
    logic es, perm, acc, pv;
    logic [7:0] ex;
    es   = sc && rel == 0;
    perm = (c == 8'h0a || c == 8'h10) ? !(sp && es) : c == 8'h0b ? sp : c == 8'h0e && sp && !es;
    acc  = !perm || (c == 8'h0b ? ix != 3'h0 : c == 8'h10 ? (ix != 3'h2 || b != 2'h1) : ix != 3'h1)
        || (c == 8'h0a && (b != 2'h0 || w1[2:0] != 3'h0))
        || (c == 8'h0e && (b > 2'h1 || (w1 != 16'h0000 && w1 != 16'h0002)));
    pv   = !acc && (c == 8'h0a ? prot[w1[15:14]] : c == 8'h0b && prot != 4'h0);
    ex   = (acc || pv) ? {2'b10, acc, pv, 4'h0}
         : {6'h20, (c == 8'h10) ? vf : (c == 8'h0a || c == 8'h0b) && (vf || vu),
            (c == 8'h10) ? vf : (c == 8'h0a || c == 8'h0b) && vu};
    sp_in <= sp;
    sc_in <= sc;
    vf_in <= vf;
    vu_in <= vu;
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h8, {16'h0, c, 6'h00, b});
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b1, 4'h8, {16'h0, w1});
    bus(1'b1, 4'h4, {29'h0, ix});
    bus(1'b1, 4'h0, 32'h80);
    bus(1'b0, 4'h0, 32'h0);
    if (!acc && !pv) chk(rd[7], 1'b0, "busy after launch");
    for (int i = 0; i < 40 && rd[7] !== 1'b1; i++) bus(1'b0, 4'h0, 32'h0);
    chk(rd[7:0] & ((acc || pv) ? 8'hb0 : 8'hff), ex, s);
    if (rd[7] !== 1'b1) end_of_test();
    if (c == 8'h0b && !acc && !pv && !vf && !vu) rel = 1;
    chk(secure_state, sc && rel == 0, "secure state");
    bus(1'b1, 4'h0, 32'h30);
    $display("Done %s", s);
  endtask : run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(85940));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h80, "status reset");
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped");
    w = 16'($urandom) & 16'hfff8;
    run(8'h0a, 1, 0, w, 0, 0, 0, 0, "erase ok");
    run(8'h0a, 0, 0, w, 0, 0, 0, 0, "erase idx");
    run(8'h0a, 1, 2, w, 0, 0, 0, 0, "erase blk");
    run(8'h0a, 1, 0, w | 16'h5, 0, 0, 0, 0, "erase align");
    run(8'h0a, 1, 0, w, 1, 1, 0, 0, "erase mode");
    run(8'h0a, 1, 0, w, 1, 0, 1, 1, "erase vunc");
    run(8'h0a, 1, 0, w, 0, 1, 1, 0, "erase verr");
    run(8'h0e, 1, 1, 16'h2, 1, 0, 0, 0, "margin ok");
    run(8'h0e, 1, 1, 16'h1, 1, 0, 0, 0, "margin level");
    run(8'h0e, 1, 3, 16'h0, 1, 0, 0, 0, "margin blk");
    run(8'h0e, 2, 0, 16'h0, 1, 0, 0, 0, "margin idx");
    run(8'h0e, 1, 0, 16'h0, 0, 0, 0, 0, "margin mode");
    run(8'h10, 2, 1, w, 0, 0, 1, 0, "section fail");
    run(8'h10, 2, 1, w, 0, 0, 0, 0, "section pass");
    run(8'h05, 0, 0, w, 1, 0, 0, 0, "bad code");
    run(8'h0b, 1, 0, w, 1, 1, 0, 0, "unsec idx");
    run(8'h0b, 0, 0, w, 0, 1, 0, 0, "unsec mode");
    run(8'h0b, 0, 0, w, 1, 1, 1, 1, "unsec fail");
    run(8'h0b, 0, 0, w, 1, 1, 0, 0, "unsec ok");
    k = 2'($urandom);
    prot = 4'h1 << k;
    bus(1'b1, 4'hc, {28'h0, prot});
    bus(1'b1, 4'hc, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, {28'h0, prot}, "protect reg");
    run(8'h0a, 1, 0, {k, w[13:0]}, 0, 0, 0, 0, "erase prot");
    run(8'h0a, 1, 0, {k + 2'h1, w[13:0]}, 0, 0, 0, 0, "erase unprot");
    run(8'h0b, 0, 0, w, 1, 0, 0, 0, "unsec prot");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
